// *** rtl/ddr_sram_regs.svh ***
// timing counts and field sizes for the burst sram interface
`ifndef DDR_SRAM_REGS_SVH
`define DDR_SRAM_REGS_SVH

`define DDR_CLK_NS 25
`define DDR_STOP_NS 30
`define DDR_STOP_CYC ((`DDR_STOP_NS + `DDR_CLK_NS - 1) / `DDR_CLK_NS)
`define DDR_STOP_SLACK 8
`define DDR_CAL_CYC 1024
`define DDR_LOCK_CYC 2048
`define DDR_BURST_LEN 2
`define DDR_DATA_W 18
`define DDR_LANES 2
`define DDR_ADDR_W 21

`endif

// *** rtl/ddr_sram_pkg.sv ***
// types shared by the burst sram interface
package ddr_sram_pkg;

	// delay-locked loop condition, one-hot
	typedef enum logic [2:0] {
		DLL_OFF = 3'b001,
		DLL_LOCKING = 3'b010,
		DLL_LOCKED = 3'b100
	} dll_state_t;

endpackage : ddr_sram_pkg

// *** rtl/bit_sync.sv ***
// two flip-flop level synchroniser
`timescale 1ns/1ps
module bit_sync #(
	parameter int WIDTH = 1
) (
	input wire logic clk, // destination clock
	input wire logic rst, // async reset, active high
	input wire logic [WIDTH-1:0] din, // level from another domain
	output logic [WIDTH-1:0] dout // synchronised level
);
	logic [WIDTH-1:0] meta_ff;

	// first stage feeds only the second stage
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			meta_ff <= '0;
			dout <= '0;
		end else begin
			meta_ff <= din;
			dout <= meta_ff;
		end
	end
endmodule : bit_sync

// *** rtl/clock_stop_detect.sv ***
// watches the link clock heartbeat and flags a stopped clock
`timescale 1ns/1ps
`include "ddr_sram_regs.svh"
module clock_stop_detect #(
	parameter int STOP_CYC = `DDR_STOP_CYC + `DDR_STOP_SLACK
) (
	input wire logic clk, // system clock
	input wire logic sys_rst, // async reset, active high
	input wire logic ce, // clock enable
	input wire logic beatToggle, // toggles on every positive link clock edge
	output logic stopped // link clock idle long enough
);
	logic beatSync;
	logic beatLast_ff;
	logic [7:0] idle_ff;

	bit_sync #(.WIDTH(1)) u_beat (
		.clk(clk),
		.rst(sys_rst),
		.din(beatToggle),
		.dout(beatSync)
	);

	// count idle system cycles since the last heartbeat change
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			beatLast_ff <= 1'b0;
			idle_ff <= 8'h00;
			stopped <= 1'b0;
		end else if (ce) begin
			beatLast_ff <= beatSync;
			if (beatSync != beatLast_ff) begin
				idle_ff <= 8'h00;
				stopped <= 1'b0;
			end else if (idle_ff < 8'(STOP_CYC)) begin
				idle_ff <= idle_ff + 8'h01;
			end else begin
				stopped <= 1'b1;
			end
		end
	end
endmodule : clock_stop_detect

// *** rtl/ddr_burst_sram_interface.sv ***
// two-word burst sram with a double data rate link
// What this block does
// R1 - controller starts read: read high, select low
// R2 - first read word 2.5 cycles later
// R3 - second read word next positive edge
// R4 - reads complete; back-to-back reads accepted
// R5 - deselected reads drain, then outputs float
// R6 - write start latches write address
// R7 - two write words stored, then pair written
// R8 - new write accepted every positive edge
// R9 - deselected writes finish, inputs then ignored
// R10 - lane enables sampled per word; masked bytes kept
// R11 - controller inserts three idle cycles read-to-write
// R12 - write after read held in registers
// R13 - held write committed on next write
// R14 - read of just-written address gets newest data
// R15 - one select line per bank in expansion
// R16 - impedance recalibrated every 1024 cycles
// R17 - two free-running echo clocks
// R18 - valid flag half cycle before data
// R19 - loop disabled gives legacy 1.0 latency
// R20 - stopped clocks reset the loop
// R21 - loop locked after 2048 stable cycles
// R22 - powers up deselected, outputs floating
// R23 - select high starts nothing, outputs float
// R24 - burst accesses address then address plus one
// R25 - clocks stopped keep previous output state
`timescale 1ns/1ps
`include "ddr_sram_regs.svh"
module ddr_burst_sram_interface
	import ddr_sram_pkg::*;
#(
	parameter int ADDR_W = `DDR_ADDR_W,
	parameter int DATA_W = `DDR_DATA_W,
	parameter int LANES = `DDR_LANES,
	parameter int CAL_CYC = `DDR_CAL_CYC,
	parameter int LOCK_CYC = `DDR_LOCK_CYC
) (
	input wire logic clk, // system clock, 40 MHz
	input wire logic sys_rst, // async reset, active high
	input wire logic ce, // freezes the recalibration and stop-detect counters when low
	input wire logic linkClk, // positive input clock of the link
	input wire logic [ADDR_W-1:0] addr, // burst start address
	input wire logic rdNotWr, // high read, low write
	input wire logic transfer_select_n, // low starts an access
	input wire logic [LANES-1:0] byte_lane_enable_n, // low writes lane
	input wire logic [DATA_W-1:0] dqIn, // data bus, input side
	output logic [DATA_W-1:0] dqOut, // data bus, output side
	output logic dqOeN, // low while driving data bus
	input wire logic loop_disable_n, // low turns the loop off
	output logic echo_timing_out, // echo of positive clock
	output logic echo_timing_out_n, // echo of negative clock
	output logic output_valid_flag, // read data valid marker
	output logic impedanceUpdate, // one-cycle recalibration pulse
	output logic dllLocked // loop lock status, system domain
);
	localparam int LANE_W = DATA_W / LANES;
	localparam int BL = `DDR_BURST_LEN;

	// --------------------------------------------------------------
	// lane merge helper
	// --------------------------------------------------------------
	function automatic logic [DATA_W-1:0] laneMerge(
		input logic [DATA_W-1:0] oldW,
		input logic [DATA_W-1:0] newW,
		input logic [LANES-1:0] en
	);
		logic [DATA_W-1:0] res;
		res = oldW;
		for (int l = 0; l < LANES; l++) begin
			if (en[l]) begin
				res[l*LANE_W +: LANE_W] = newW[l*LANE_W +: LANE_W];
			end
		end
		return res;
	endfunction : laneMerge

	// --------------------------------------------------------------
	// link-side reset and synchronisers
	// --------------------------------------------------------------
	logic [1:0] linkRst_ff;
	logic linkRst;
	logic loopOnSync;
	logic stopSync;
	logic clkStopped;
	logic beat_ff;
	dll_state_t dllState_ff;

	// reset asserts at once, releases on the link clock
	always_ff @(posedge linkClk or posedge sys_rst) begin
		if (sys_rst) begin
			linkRst_ff <= 2'b11;
		end else begin
			linkRst_ff <= {linkRst_ff[0], 1'b0};
		end
	end
	assign linkRst = linkRst_ff[1];

	bit_sync #(.WIDTH(1)) u_loop_sync (
		.clk(linkClk),
		.rst(linkRst),
		.din(loop_disable_n),
		.dout(loopOnSync)
	);

	bit_sync #(.WIDTH(1)) u_stop_sync (
		.clk(linkClk),
		.rst(linkRst),
		.din(clkStopped),
		.dout(stopSync)
	);

	bit_sync #(.WIDTH(1)) u_lock_sync (
		.clk(clk),
		.rst(sys_rst),
		.din(dllState_ff == DLL_LOCKED),
		.dout(dllLocked)
	);

	// heartbeat toggles on each positive link edge so the system side can
	// tell a running clock from a stopped one
	always_ff @(posedge linkClk or posedge linkRst) begin
		if (linkRst) begin
			beat_ff <= 1'b0;
		end else begin
			beat_ff <= ~beat_ff;
		end
	end

	// R20 stop detection
	clock_stop_detect u_stop (
		.clk(clk),
		.sys_rst(sys_rst),
		.ce(ce),
		.beatToggle(beat_ff),
		.stopped(clkStopped)
	);

	// --------------------------------------------------------------
	// system side: impedance recalibration
	// --------------------------------------------------------------
	logic [10:0] calCnt_ff;

	// R16 periodic recalibration
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			calCnt_ff <= 11'h000;
			impedanceUpdate <= 1'b0;
		end else if (ce) begin
			impedanceUpdate <= (calCnt_ff == 11'(CAL_CYC - 1));
			if (calCnt_ff == 11'(CAL_CYC - 1)) begin
				calCnt_ff <= 11'h000;
			end else begin
				calCnt_ff <= calCnt_ff + 11'h001;
			end
		end
	end

	// --------------------------------------------------------------
	// delay-locked loop state
	// --------------------------------------------------------------
	logic [11:0] lockCnt_ff;
	logic legacy;

	// R21 lock count, R20 restart after a stop
	always_ff @(posedge linkClk or posedge linkRst) begin
		if (linkRst) begin
			dllState_ff <= DLL_LOCKING;
			lockCnt_ff <= 12'h000;
		end else begin
			unique case (dllState_ff)
				DLL_OFF: begin
					if (loopOnSync) begin
						dllState_ff <= DLL_LOCKING;
						lockCnt_ff <= 12'h000;
					end
				end
				DLL_LOCKING: begin
					if (!loopOnSync) begin
						dllState_ff <= DLL_OFF;
					end else if (stopSync) begin
						lockCnt_ff <= 12'h000;
					end else if (lockCnt_ff == 12'(LOCK_CYC - 1)) begin
						dllState_ff <= DLL_LOCKED;
					end else begin
						lockCnt_ff <= lockCnt_ff + 12'h001;
					end
				end
				DLL_LOCKED: begin
					if (!loopOnSync) begin
						dllState_ff <= DLL_OFF;
					end else if (stopSync) begin
						dllState_ff <= DLL_LOCKING;
						lockCnt_ff <= 12'h000;
					end
				end
				default: begin
					dllState_ff <= DLL_LOCKING;
					lockCnt_ff <= 12'h000;
				end
			endcase
		end
	end

	// R19 loop off selects legacy timing
	assign legacy = (dllState_ff == DLL_OFF);

	// --------------------------------------------------------------
	// command decode and memory array
	// --------------------------------------------------------------
	logic rdCmd;
	logic wrCmd;
	logic [DATA_W-1:0] mem [0:(1<<ADDR_W)-1];

	// R23 select high decodes to nothing
	assign rdCmd = !transfer_select_n && rdNotWr;
	assign wrCmd = !transfer_select_n && !rdNotWr;

	// --------------------------------------------------------------
	// write pipeline
	// --------------------------------------------------------------
	logic wrP0_ff;
	logic wrP1_ff;
	logic [ADDR_W-1:0] wrAddr_ff;
	logic [ADDR_W-1:0] asmAddr_ff;
	logic [DATA_W-1:0] asmData0_ff;
	logic [DATA_W-1:0] asmData1_ff;
	logic [LANES-1:0] asmEn0_ff;
	logic [LANES-1:0] asmEn1_ff;
	logic postValid_ff;
	logic [ADDR_W-1:0] postAddr_ff;
	logic [BL-1:0][DATA_W-1:0] postData_ff;
	logic [BL-1:0][LANES-1:0] postEn_ff;

	// R6 write address capture, R8 one write per edge
	always_ff @(posedge linkClk or posedge linkRst) begin
		if (linkRst) begin
			wrP0_ff <= 1'b0;
			wrP1_ff <= 1'b0;
			wrAddr_ff <= '0;
		end else begin
			wrP0_ff <= wrCmd;
			wrP1_ff <= wrP0_ff;
			if (wrCmd) begin
				wrAddr_ff <= addr;
			end
		end
	end

	// R9 started pair completes after deselect
	// R7 first write word, R10 lane enables with it
	always_ff @(posedge linkClk or posedge linkRst) begin
		if (linkRst) begin
			asmAddr_ff <= '0;
			asmData0_ff <= '0;
			asmEn0_ff <= '0;
		end else if (wrP0_ff) begin
			asmAddr_ff <= wrAddr_ff;
			asmData0_ff <= dqIn;
			asmEn0_ff <= ~byte_lane_enable_n;
		end
	end

	// R7 second write word on the negative clock rise
	always_ff @(negedge linkClk or posedge linkRst) begin
		if (linkRst) begin
			asmData1_ff <= '0;
			asmEn1_ff <= '0;
		end else if (wrP1_ff) begin
			asmData1_ff <= dqIn;
			asmEn1_ff <= ~byte_lane_enable_n;
		end
	end

	// R12 completed pair parks in the posted registers so a
	// following read never fights the array write
	always_ff @(posedge linkClk or posedge linkRst) begin
		if (linkRst) begin
			postValid_ff <= 1'b0;
			postAddr_ff <= '0;
			postData_ff <= '0;
			postEn_ff <= '0;
		end else if (wrP1_ff) begin
			postValid_ff <= 1'b1;
			postAddr_ff <= asmAddr_ff;
			postData_ff <= {asmData1_ff, asmData0_ff};
			postEn_ff <= {asmEn1_ff, asmEn0_ff};
		end else if (wrCmd) begin
			postValid_ff <= 1'b0;
		end
	end

	// R13 commit on the next write, R24 address then plus one
	always_ff @(posedge linkClk) begin
		if (postValid_ff && (wrCmd || wrP1_ff)) begin
			for (int w = 0; w < BL; w++) begin
				mem[ADDR_W'(postAddr_ff + ADDR_W'(w))] <= laneMerge(
					mem[ADDR_W'(postAddr_ff + ADDR_W'(w))],
					postData_ff[w], postEn_ff[w]);
			end
		end
	end

	// --------------------------------------------------------------
	// read pipeline with forwarding
	// --------------------------------------------------------------
	logic rdS1_ff;
	logic rdS2_ff;
	logic rdS3_ff;
	logic [ADDR_W-1:0] rdAddr_ff;
	logic [BL-1:0][DATA_W-1:0] rdPair;
	logic [BL-1:0][DATA_W-1:0] rdDataS2_ff;
	logic [BL-1:0][DATA_W-1:0] rdDataS3_ff;

	// R14 newest data wins: pair in flight, then posted, then array
	always_comb begin
		logic [ADDR_W-1:0] a;
		a = '0;
		for (int w = 0; w < BL; w++) begin
			a = ADDR_W'(rdAddr_ff + ADDR_W'(w));
			rdPair[w] = mem[a];
			for (int p = 0; p < BL; p++) begin
				if (postValid_ff && a == ADDR_W'(postAddr_ff + ADDR_W'(p))) begin
					rdPair[w] = laneMerge(rdPair[w], postData_ff[p],
						postEn_ff[p]);
				end
			end
			if (wrP1_ff && a == asmAddr_ff) begin
				rdPair[w] = laneMerge(rdPair[w], asmData0_ff, asmEn0_ff);
			end
			if (wrP1_ff && a == ADDR_W'(asmAddr_ff + ADDR_W'(1))) begin
				rdPair[w] = laneMerge(rdPair[w], asmData1_ff, asmEn1_ff);
			end
		end
	end

	// R1 read accepted, R4 every edge, stages run to completion
	always_ff @(posedge linkClk or posedge linkRst) begin
		if (linkRst) begin
			rdS1_ff <= 1'b0;
			rdS2_ff <= 1'b0;
			rdS3_ff <= 1'b0;
			rdAddr_ff <= '0;
			rdDataS2_ff <= '0;
			rdDataS3_ff <= '0;
		end else begin
			rdS1_ff <= rdCmd;
			rdS2_ff <= rdS1_ff;
			rdS3_ff <= rdS2_ff;
			if (rdCmd) begin
				rdAddr_ff <= addr;
			end
			rdDataS2_ff <= rdPair;
			rdDataS3_ff <= rdDataS2_ff;
		end
	end

	// --------------------------------------------------------------
	// double data rate output registers
	// --------------------------------------------------------------
	logic [DATA_W-1:0] dqPos_ff;
	logic [DATA_W-1:0] dqNeg_ff;
	logic oePos_ff;
	logic oeNeg_ff;
	logic vldPos_ff;
	logic vldNeg_ff;

	// R3 second word on the positive rise (legacy: first word)
	always_ff @(posedge linkClk or posedge linkRst) begin
		if (linkRst) begin
			dqPos_ff <= '0;
			oePos_ff <= 1'b0;
			vldPos_ff <= 1'b0;
		end else if (legacy) begin
			dqPos_ff <= rdPair[0];
			oePos_ff <= rdS1_ff;
			vldPos_ff <= rdS1_ff;
		end else begin
			dqPos_ff <= rdDataS3_ff[1];
			oePos_ff <= rdS3_ff;
			vldPos_ff <= rdS2_ff;
		end
	end

	// R2 first word on the negative rise after two positive edges
	// R5 no pending burst means the bus floats after this edge
	always_ff @(negedge linkClk or posedge linkRst) begin
		if (linkRst) begin
			dqNeg_ff <= '0;
			oeNeg_ff <= 1'b0;
			vldNeg_ff <= 1'b0;
		end else if (legacy) begin
			dqNeg_ff <= rdDataS2_ff[1];
			oeNeg_ff <= rdS2_ff;
			vldNeg_ff <= rdS1_ff;
		end else begin
			dqNeg_ff <= rdDataS3_ff[0];
			oeNeg_ff <= rdS3_ff;
			vldNeg_ff <= rdS3_ff;
		end
	end

	// R18 valid leads its data by half a cycle
	// R22 all enables reset low, so the bus floats at power up
	// R25 a stopped clock freezes the selected phase register
	assign dqOut = linkClk ? dqPos_ff : dqNeg_ff;
	assign dqOeN = linkClk ? ~oePos_ff : ~oeNeg_ff;
	assign output_valid_flag = linkClk ? vldPos_ff : vldNeg_ff;

	// R17 echo clocks follow the input clock pair
	assign echo_timing_out = linkClk;
	assign echo_timing_out_n = ~linkClk;

endmodule : ddr_burst_sram_interface

// *** tb/ddr_sram_chk.sv ***
// port assertions for the burst sram interface
`timescale 1ns/1ps
module ddr_sram_chk #(
	parameter int CAL_CYC = 1024,
	parameter int LOCK_CYC = 2048
) (
	input wire logic clk, // system clock
	input wire logic sys_rst, // async reset
	input wire logic ce, // clock enable
	input wire logic linkClk, // link clock
	input wire logic rdNotWr, // read or write
	input wire logic transfer_select_n, // access select
	input wire logic dqOeN, // bus drive, low active
	input wire logic loop_disable_n, // loop off pin
	input wire logic echo_timing_out, // echo clock
	input wire logic echo_timing_out_n, // inverted echo
	input wire logic output_valid_flag, // read valid
	input wire logic impedanceUpdate, // recal pulse
	input wire logic dllLocked // lock status
);
	// ----------------
	// helper history
	// ----------------
	logic [2:0] rdHist_ff; // reads at the last three rises
	logic [7:0] loopHist_ff; // loop pin, eight rises deep
	int lockRises_ff; // rises with the loop pin high
	int calCnt_ff; // enabled clocks since last pulse
	logic calSeen_ff; // first pulse has passed
	wire logic rdCmd = rdNotWr && !transfer_select_n;
	wire logic modeNew = &loopHist_ff;
	wire logic modeOld = ~|loopHist_ff;

	// deep pin history because the pin crosses a synchroniser
	always_ff @(posedge linkClk or posedge sys_rst) begin
		if (sys_rst) begin
			rdHist_ff <= '0;
			loopHist_ff <= '0;
			lockRises_ff <= 0;
		end else begin
			rdHist_ff <= {rdHist_ff[1:0], rdCmd};
			loopHist_ff <= {loopHist_ff[6:0], loop_disable_n};
			if (!loop_disable_n)
				lockRises_ff <= 0;
			else if (lockRises_ff < LOCK_CYC)
				lockRises_ff <= lockRises_ff + 1;
		end
	end

	// spacing of recalibration pulses
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			calCnt_ff <= 0;
			calSeen_ff <= 1'b0;
		end else if (ce) begin
			calCnt_ff <= impedanceUpdate ? 0 : calCnt_ff + 1;
			calSeen_ff <= calSeen_ff | impedanceUpdate;
		end
	end

	read_latency_a: assert property (@(posedge linkClk) disable iff (sys_rst)
		rdCmd && modeNew |-> ##3 (output_valid_flag && !dqOeN))
		else $error("read data late or missing");
	legacy_valid_a: assert property (@(posedge linkClk) disable iff (sys_rst)
		rdCmd && modeOld |-> ##1 output_valid_flag)
		else $error("legacy read valid late");
	idle_float_a: assert property (@(posedge linkClk) disable iff (sys_rst)
		rdHist_ff == 3'b000 |-> dqOeN && !output_valid_flag)
		else $error("bus driven without a read");
	normal_drive_a: assert property (@(posedge linkClk) disable iff (sys_rst)
		modeNew && !dqOeN |-> rdHist_ff[2])
		else $error("bus driven at wrong latency");
	echo_clock_a: assert property (@(posedge clk) disable iff (sys_rst)
		echo_timing_out == linkClk && echo_timing_out_n == !linkClk)
		else $error("echo clocks off");
	cal_period_a: assert property (@(posedge clk) disable iff (sys_rst)
		calSeen_ff && ce |-> (impedanceUpdate ? calCnt_ff == CAL_CYC - 1
		: calCnt_ff < CAL_CYC - 1))
		else $error("recal pulse spacing wrong");
	lock_wait_a: assert property (@(posedge clk) disable iff (sys_rst)
		$rose(dllLocked) |-> lockRises_ff >= LOCK_CYC)
		else $error("lock reported too early");
	reset_quiet_a: assert property (@(posedge clk) disable iff (sys_rst)
		$fell(sys_rst) |-> dqOeN && !output_valid_flag && !dllLocked)
		else $error("outputs active after reset");
endmodule : ddr_sram_chk

bind ddr_burst_sram_interface ddr_sram_chk #(.CAL_CYC(CAL_CYC),
	.LOCK_CYC(LOCK_CYC)) u_chk (.clk(clk), .sys_rst(sys_rst), .ce(ce),
	.linkClk(linkClk), .rdNotWr(rdNotWr),
	.transfer_select_n(transfer_select_n), .dqOeN(dqOeN),
	.loop_disable_n(loop_disable_n), .echo_timing_out(echo_timing_out),
	.echo_timing_out_n(echo_timing_out_n),
	.output_valid_flag(output_valid_flag),
	.impedanceUpdate(impedanceUpdate), .dllLocked(dllLocked));

// *** tb/ctrl_link_model.sv ***
// memory controller model on the link side of the sram
`timescale 1ns/1ps
module ctrl_link_model #(
	parameter int ADDR_W = 8,
	parameter int DATA_W = 18,
	parameter int LANES = 2
) (
	input wire logic linkClk, // positive input clock
	input wire logic [DATA_W-1:0] dqOut, // read data
	input wire logic dqOeN, // low while sram drives
	output logic [ADDR_W-1:0] addr, // burst start address
	output logic rdNotWr, // high read
	output logic transfer_select_n, // low starts access
	output logic [LANES-1:0] byte_lane_enable_n, // lane enables
	output logic [DATA_W-1:0] dqIn // write data
);
	logic [DATA_W-1:0] rdq[$]; // words seen on the bus

	initial begin
		addr = '0;
		rdNotWr = 1'b1;
		transfer_select_n = 1'b1;
		byte_lane_enable_n = '1;
		dqIn = '0;
	end

	// capture mid half-cycle, where each word is settled
	always @(linkClk) begin
		#40;
		if (dqOeN === 1'b0)
			rdq.push_back(dqOut);
	end

	// one select line, command held a whole cycle
	task automatic cmd(input logic rd, input logic [ADDR_W-1:0] a);
		@(posedge linkClk);
		#2;
		transfer_select_n = 1'b0;
		rdNotWr = rd;
		addr = a;
	endtask : cmd

	task automatic rd(input logic [ADDR_W-1:0] a);
		cmd(1'b1, a);
		dqIn = ~dqIn; // released data lines never keep their value
	endtask : rd

	// word0 valid at the next rise, word1 at the fall after
	task automatic wr(input logic [ADDR_W-1:0] a, input logic [17:0] d0,
		input logic [17:0] d1, input logic [1:0] l0, input logic [1:0] l1);
		cmd(1'b0, a);
		@(posedge linkClk);
		#2;
		transfer_select_n = 1'b1;
		addr = ~addr;
		dqIn = d0;
		byte_lane_enable_n = l0;
		// word1 stands from just after this rise across the fall
		@(posedge linkClk);
		#2;
		dqIn = d1;
		byte_lane_enable_n = l1;
	endtask : wr

	// idle cycles keep the select high
	task automatic idle(input int n);
		repeat (n) begin
			@(posedge linkClk);
			#2;
			transfer_select_n = 1'b1;
			addr = ~addr;
			dqIn = ~dqIn;
		end
	endtask : idle
endmodule : ctrl_link_model

// *** tb/test_ddr_burst_sram_interface.sv ***
// self-checking bench for the burst sram interface
`timescale 1ns/1ps
`define CHK(g, e) begin samplesChecked++; if ((g) !== (e)) begin \
	failCount++; \
	$display("unexpected at %0t: got %h exp %h", $time, (g), (e)); \
	end end
module test_ddr_burst_sram_interface
	import ddr_sram_pkg::*;
;
	localparam int CAL = 16;
	localparam int LOCK = 16;
	logic clk = 1'b0, sys_rst = 1'b0, ce = 1'b1, linkClk = 1'b0;
	logic linkRun = 1'b1, loop_disable_n = 1'b1;
	logic [7:0] addr;
	logic rdNotWr, transfer_select_n, dqOeN, echo_timing_out;
	logic echo_timing_out_n, output_valid_flag, impedanceUpdate, dllLocked;
	logic [1:0] byte_lane_enable_n;
	logic [17:0] dqIn, dqOut;
	int failCount = 0, samplesChecked = 0;

	always #12.5 clk = ~clk;
	// link clock halts where it stands when linkRun drops
	always begin
		#80;
		if (linkRun)
			linkClk = ~linkClk;
	end

	ddr_burst_sram_interface #(.ADDR_W(8), .CAL_CYC(CAL), .LOCK_CYC(LOCK))
	u_dut (.clk(clk), .sys_rst(sys_rst), .ce(ce), .linkClk(linkClk),
		.addr(addr), .rdNotWr(rdNotWr), .transfer_select_n(transfer_select_n),
		.byte_lane_enable_n(byte_lane_enable_n), .dqIn(dqIn), .dqOut(dqOut),
		.dqOeN(dqOeN), .loop_disable_n(loop_disable_n),
		.echo_timing_out(echo_timing_out),
		.echo_timing_out_n(echo_timing_out_n),
		.output_valid_flag(output_valid_flag),
		.impedanceUpdate(impedanceUpdate), .dllLocked(dllLocked));

	ctrl_link_model #(.ADDR_W(8)) u_ctrl (.linkClk(linkClk), .dqOut(dqOut),
		.dqOeN(dqOeN), .addr(addr), .rdNotWr(rdNotWr),
		.transfer_select_n(transfer_select_n),
		.byte_lane_enable_n(byte_lane_enable_n), .dqIn(dqIn));

	task automatic giveVerdict();
		$display("checks %0d mismatches %0d", samplesChecked, failCount);
		if (failCount == 0 && samplesChecked > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask : giveVerdict

	// compare captured read words in order
	task automatic cmpWords(input logic [17:0] exp[$]);
		`CHK(u_ctrl.rdq.size(), exp.size())
		foreach (exp[i])
			`CHK(u_ctrl.rdq[i], exp[i])
		u_ctrl.rdq.delete();
	endtask : cmpWords

	task automatic tLock();
		int n;
		n = 0;
		while (dllLocked !== 1'b1 && n < LOCK + 20) begin
			@(posedge linkClk);
			n++;
		end
		`CHK(dllLocked, 1'b1)
		`CHK(n >= LOCK - 4, 1'b1)
		$display("lock test done");
	endtask : tLock

	// posted write, lane masks, forwarding, wrap of the burst address
	task automatic tReadWrite();
		u_ctrl.wr(8'h10, 18'h2a5a5, 18'h15a5a, 2'b00, 2'b00);
		u_ctrl.wr(8'h10, 18'h3ffff, 18'h3ffff, 2'b10, 2'b11);
		u_ctrl.rd(8'h10);
		u_ctrl.rd(8'h10);
		u_ctrl.idle(3);
		u_ctrl.wr(8'hff, 18'h0c3c3, 18'h30f0f, 2'b00, 2'b00);
		u_ctrl.rd(8'hff);
		u_ctrl.rd(8'h10);
		u_ctrl.idle(6);
		cmpWords('{18'h2a5ff, 18'h15a5a, 18'h2a5ff, 18'h15a5a,
			18'h0c3c3, 18'h30f0f, 18'h2a5ff, 18'h15a5a});
		$display("read write test done");
	endtask : tReadWrite

	// legacy mode still returns the same words, one and a half cycles sooner
	task automatic tLegacy();
		@(posedge clk);
		#2;
		loop_disable_n = 1'b0;
		u_ctrl.idle(8);
		u_ctrl.rd(8'h10);
		u_ctrl.idle(4);
		cmpWords('{18'h2a5ff, 18'h15a5a});
		@(posedge clk);
		#2;
		loop_disable_n = 1'b1;
		tLock();
		$display("legacy test done");
	endtask : tLegacy

	// stop the link clock high for a microsecond: the bus keeps its
	// idle state while stopped, and the loop relocks after restart
	task automatic tStop();
		logic seen;
		seen = 1'b0;
		@(posedge linkClk);
		#2;
		linkRun = 1'b0;
		repeat (40) @(posedge clk);
		#2;
		`CHK(linkClk, 1'b1)
		`CHK(dqOeN, 1'b1)
		`CHK(output_valid_flag, 1'b0)
		linkRun = 1'b1;
		// short window so most of the relock is left for tLock
		repeat (25) begin
			@(posedge clk);
			#2;
			if (dllLocked === 1'b0)
				seen = 1'b1;
		end
		`CHK(seen, 1'b1)
		tLock();
		$display("stop test done");
	endtask : tStop

	// pulse count over four periods, then ce low must freeze the pulse train
	task automatic tCal();
		int pulses;
		int moves;
		logic last;
		pulses = 0;
		moves = 0;
		repeat (4 * CAL) begin
			@(posedge clk);
			#2;
			if (impedanceUpdate === 1'b1)
				pulses++;
		end
		`CHK(pulses, 4)
		ce = 1'b0;
		last = impedanceUpdate;
		repeat (2 * CAL) begin
			@(posedge clk);
			#2;
			if (impedanceUpdate !== last)
				moves++;
		end
		ce = 1'b1;
		`CHK(moves, 0)
		$display("recal test done");
	endtask : tCal

	// reset rises just after time zero so the async edge is seen
	initial begin
		#2;
		sys_rst = 1'b1;
		repeat (2) @(posedge clk);
		#2;
		sys_rst = 1'b0;
		repeat (3) @(posedge linkClk);
		`CHK(dqOeN, 1'b1)
		`CHK(output_valid_flag, 1'b0)
		tLock();
		tReadWrite();
		tLegacy();
		tStop();
		tCal();
		giveVerdict();
	end

	// watchdog, about ten times the expected run
	initial begin
		#200000;
		failCount++;
		giveVerdict();
	end
endmodule : test_ddr_burst_sram_interface
